// file: include/dds_regs_pkg.sv
// Register map, field layout and reset values of the tuning, sync and ramp bank
package dds_regs_pkg;
   localparam logic [7:0] ADDR_FREQUENCY_WORD = 8'h07;
   localparam logic [7:0] ADDR_PHASE_OFFSET = 8'h08;
   localparam logic [7:0] ADDR_AMPLITUDE_SCALE = 8'h09;
   localparam logic [7:0] ADDR_MULTICHIP_SYNC = 8'h0a;
   localparam logic [7:0] ADDR_RAMP_LIMITS = 8'h0b;
   localparam logic [7:0] ADDR_RAMP_STEPS = 8'h0c;
   localparam logic [7:0] ADDR_RAMP_RATES = 8'h0d;
   localparam int FIRST_ADDR = 7;
   localparam int NUM_REGS = 7;
   // Byte counts per register
   localparam logic [3:0] BYTES_FREQUENCY_WORD = 4'h4;
   localparam logic [3:0] BYTES_PHASE_OFFSET = 4'h2;
   localparam logic [3:0] BYTES_AMPLITUDE_SCALE = 4'h4;
   localparam logic [3:0] BYTES_MULTICHIP_SYNC = 4'h4;
   localparam logic [3:0] BYTES_RAMP_LIMITS = 4'h8;
   localparam logic [3:0] BYTES_RAMP_STEPS = 4'h8;
   localparam logic [3:0] BYTES_RAMP_RATES = 4'h4;
   // Writable bit masks; open bits stay zero
   localparam logic [63:0] MASK_PHASE_OFFSET = 64'h0000_0000_0000_ffff;
   localparam logic [63:0] MASK_WORD32 = 64'h0000_0000_ffff_ffff;
   localparam logic [63:0] MASK_MULTICHIP_SYNC = 64'h0000_0000_fefc_f8f8;
   localparam logic [63:0] MASK_WORD64 = 64'hffff_ffff_ffff_ffff;
   localparam logic [63:0] RESET_VALUE = 64'h0000_0000_0000_0000;
   // Amplitude scale fields
   localparam int ASF_RATE_HI = 31;
   localparam int ASF_RATE_LO = 16;
   localparam int ASF_SCALE_HI = 15;
   localparam int ASF_SCALE_LO = 2;
   localparam int ASF_STEP_HI = 1;
   localparam int ASF_STEP_LO = 0;
   localparam logic [1:0] KEYING_AUTO = 2'h3;
   // Multichip sync fields
   localparam int SYNC_VALID_HI = 31;
   localparam int SYNC_VALID_LO = 28;
   localparam int SYNC_RX_EN_BIT = 27;
   localparam int SYNC_GEN_EN_BIT = 26;
   localparam int SYNC_GEN_POL_BIT = 25;
   localparam int SYNC_PRESET_HI = 23;
   localparam int SYNC_PRESET_LO = 18;
   localparam int SYNC_OUT_DLY_HI = 15;
   localparam int SYNC_OUT_DLY_LO = 11;
   localparam int SYNC_IN_DLY_HI = 7;
   localparam int SYNC_IN_DLY_LO = 3;
   // Ramp fields
   localparam int RAMP_HI_HI = 63;
   localparam int RAMP_HI_LO = 32;
   localparam int RAMP_LO_HI = 31;
   localparam int RAMP_LO_LO = 0;
   localparam int RATE_NEG_HI = 31;
   localparam int RATE_NEG_LO = 16;
   localparam int RATE_POS_HI = 15;
   localparam int RATE_POS_LO = 0;
endpackage : dds_regs_pkg

// file: src/dds_reg_store.sv
// Storage of the seven registers, read data registered
`timescale 1ns/10ps
module dds_reg_store
   import dds_regs_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic wr_en,
   input wire logic [2:0] wr_idx,
   input wire logic [63:0] wr_data,
   input wire logic [2:0] rd_idx,
   output logic [63:0] rd_data_q,
   output logic [NUM_REGS*64-1:0] all_q
);
   // ==========================================
   // Mask table
   function automatic logic [63:0] mask_of(input int i);
      case (i)
         0: mask_of = MASK_WORD32;
         1: mask_of = MASK_PHASE_OFFSET;
         2: mask_of = MASK_WORD32;
         3: mask_of = MASK_MULTICHIP_SYNC;
         4: mask_of = MASK_WORD64;
         5: mask_of = MASK_WORD64;
         6: mask_of = MASK_WORD32;
         default: mask_of = RESET_VALUE;
      endcase
   endfunction : mask_of

   // ==========================================
   // Entries
   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g++) begin : g_reg
         logic [63:0] reg_q;
         always_ff @(posedge CLOCK) begin
            if (RST) begin
               reg_q <= RESET_VALUE;
            end else if (wr_en && wr_idx == 3'(g)) begin
               reg_q <= wr_data & mask_of(g);
            end
         end
         assign all_q[g*64 +: 64] = reg_q;
      end
   endgenerate

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         rd_data_q <= RESET_VALUE;
      end else if (rd_idx < 3'(NUM_REGS)) begin
         rd_data_q <= all_q[rd_idx*64 +: 64];
      end else begin
         rd_data_q <= RESET_VALUE;
      end
   end
endmodule : dds_reg_store

// file: src/dds_tuning_sync_ramp_regs.sv
// Tuning, multichip sync and ramp register bank with byte-serial access
`timescale 1ns/10ps
module dds_tuning_sync_ramp_regs
   import dds_regs_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic ACCESS_START,
   input wire logic ACCESS_WRITE,
   input wire logic [7:0] ACCESS_ADDR,
   input wire logic BYTE_VALID,
   input wire logic [7:0] BYTE_IN,
   input wire logic [1:0] KEYING_CONTROL,
   input wire logic RAMP_ENABLE,
   output logic [7:0] BYTE_OUT,
   output logic BYTE_OUT_VALID,
   output logic ACCESS_DONE,
   output logic ADDR_ERROR,
   output logic [31:0] FREQUENCY_WORD,
   output logic [15:0] PHASE_OFFSET,
   output logic [13:0] AMPLITUDE_SCALE,
   output logic [15:0] AMPLITUDE_RAMP_RATE,
   output logic [1:0] AMPLITUDE_STEP,
   output logic [3:0] SYNC_VALIDATION_DELAY,
   output logic SYNC_RECEIVER_ENABLE,
   output logic SYNC_GENERATOR_ENABLE,
   output logic SYNC_GENERATOR_FALLING,
   output logic [5:0] SYNC_STATE_PRESET,
   output logic [4:0] SYNC_OUTPUT_DELAY,
   output logic [4:0] SYNC_INPUT_DELAY,
   output logic [31:0] RAMP_UPPER_LIMIT,
   output logic [31:0] RAMP_LOWER_LIMIT,
   output logic [31:0] RAMP_DECREMENT_STEP,
   output logic [31:0] RAMP_INCREMENT_STEP,
   output logic [15:0] RAMP_DECREMENT_RATE,
   output logic [15:0] RAMP_INCREMENT_RATE
);
   // ==========================================
   // Access sequencer
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_WRITE = 4'b0010,
      S_READ = 4'b0100,
      S_COMMIT = 4'b1000
   } state_t;

   state_t state_q;
   logic [2:0] idx_q;
   logic [3:0] count_q;
   logic [3:0] len_q;
   logic [63:0] shift_q;
   logic wr_en;
   logic [63:0] rd_data_q;
   logic [NUM_REGS*64-1:0] all_q;
   logic addr_ok;
   logic [3:0] len_of_addr;
   logic [2:0] idx_of_addr;
   logic [2:0] rd_sel;

   always_comb begin
      addr_ok = 1'b1;
      len_of_addr = BYTES_FREQUENCY_WORD;
      case (ACCESS_ADDR)
         ADDR_FREQUENCY_WORD: len_of_addr = BYTES_FREQUENCY_WORD;
         ADDR_PHASE_OFFSET: len_of_addr = BYTES_PHASE_OFFSET;
         ADDR_AMPLITUDE_SCALE: len_of_addr = BYTES_AMPLITUDE_SCALE;
         ADDR_MULTICHIP_SYNC: len_of_addr = BYTES_MULTICHIP_SYNC;
         ADDR_RAMP_LIMITS: len_of_addr = BYTES_RAMP_LIMITS;
         ADDR_RAMP_STEPS: len_of_addr = BYTES_RAMP_STEPS;
         ADDR_RAMP_RATES: len_of_addr = BYTES_RAMP_RATES;
         default: addr_ok = 1'b0;
      endcase
      idx_of_addr = 3'(ACCESS_ADDR - 8'(FIRST_ADDR));
   end

   // Bytes arrive most significant first, as on the serial port
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         state_q <= S_IDLE;
         idx_q <= 3'h0;
         count_q <= 4'h0;
         len_q <= 4'h0;
         shift_q <= RESET_VALUE;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (ACCESS_START && addr_ok) begin
                  idx_q <= idx_of_addr;
                  len_q <= len_of_addr;
                  count_q <= 4'h0;
                  shift_q <= RESET_VALUE;
                  state_q <= ACCESS_WRITE ? S_WRITE : S_READ;
               end
            end
            S_WRITE: begin
               if (BYTE_VALID) begin
                  shift_q <= {shift_q[55:0], BYTE_IN};
                  count_q <= count_q + 4'h1;
                  if (count_q + 4'h1 == len_q) begin
                     state_q <= S_COMMIT;
                  end
               end
            end
            S_COMMIT: state_q <= S_IDLE;
            S_READ: begin
               // Read data register loads on the same edge as the index capture, so the shift register takes it one cycle later
               if (count_q == 4'h0) begin
                  shift_q <= rd_data_q << (7'(8 - len_q) * 7'd8);
                  count_q <= 4'h1;
               end else if (BYTE_VALID) begin
                  shift_q <= {shift_q[55:0], 8'h00};
                  count_q <= count_q + 4'h1;
                  if (count_q == len_q) begin
                     state_q <= S_IDLE;
                  end
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   assign wr_en = (state_q == S_COMMIT);
   // Store index follows the address while idle, so a read never loads stale data
   assign rd_sel = (state_q == S_IDLE) ? idx_of_addr : idx_q;

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         BYTE_OUT <= 8'h00;
         BYTE_OUT_VALID <= 1'b0;
         ACCESS_DONE <= 1'b0;
         ADDR_ERROR <= 1'b0;
      end else begin
         BYTE_OUT_VALID <= (state_q == S_READ) && BYTE_VALID && count_q != 4'h0;
         BYTE_OUT <= shift_q[63:56];
         ACCESS_DONE <= wr_en || ((state_q == S_READ) && BYTE_VALID && count_q == len_q);
         ADDR_ERROR <= ACCESS_START && (state_q == S_IDLE) && !addr_ok;
      end
   end

   dds_reg_store u_store (
      .CLOCK(CLOCK),
      .RST(RST),
      .wr_en(wr_en),
      .wr_idx(idx_q),
      .wr_data(shift_q),
      .rd_idx(rd_sel),
      .rd_data_q(rd_data_q),
      .all_q(all_q)
   );

   // ==========================================
   // Field outputs
   logic [63:0] r_freq, r_phase, r_amp, r_sync, r_lim, r_step, r_rate;
   assign r_freq = all_q[0*64 +: 64];
   assign r_phase = all_q[1*64 +: 64];
   assign r_amp = all_q[2*64 +: 64];
   assign r_sync = all_q[3*64 +: 64];
   assign r_lim = all_q[4*64 +: 64];
   assign r_step = all_q[5*64 +: 64];
   assign r_rate = all_q[6*64 +: 64];

   logic keying_auto;
   assign keying_auto = (KEYING_CONTROL == KEYING_AUTO);

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         FREQUENCY_WORD <= 32'h0;
         PHASE_OFFSET <= 16'h0;
         AMPLITUDE_SCALE <= 14'h0;
         AMPLITUDE_RAMP_RATE <= 16'h0;
         AMPLITUDE_STEP <= 2'h0;
      end else begin
         FREQUENCY_WORD <= r_freq[31:0];
         PHASE_OFFSET <= r_phase[15:0];
         AMPLITUDE_SCALE <= r_amp[ASF_SCALE_HI:ASF_SCALE_LO];
         AMPLITUDE_RAMP_RATE <= keying_auto ? r_amp[ASF_RATE_HI:ASF_RATE_LO] : 16'h0;
         AMPLITUDE_STEP <= keying_auto ? r_amp[ASF_STEP_HI:ASF_STEP_LO] : 2'h0;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         SYNC_VALIDATION_DELAY <= 4'h0;
         SYNC_RECEIVER_ENABLE <= 1'b0;
         SYNC_GENERATOR_ENABLE <= 1'b0;
         SYNC_GENERATOR_FALLING <= 1'b0;
         SYNC_STATE_PRESET <= 6'h0;
         SYNC_OUTPUT_DELAY <= 5'h0;
         SYNC_INPUT_DELAY <= 5'h0;
      end else begin
         SYNC_VALIDATION_DELAY <= r_sync[SYNC_VALID_HI:SYNC_VALID_LO];
         SYNC_RECEIVER_ENABLE <= r_sync[SYNC_RX_EN_BIT];
         SYNC_GENERATOR_ENABLE <= r_sync[SYNC_GEN_EN_BIT];
         SYNC_GENERATOR_FALLING <= r_sync[SYNC_GEN_POL_BIT];
         SYNC_STATE_PRESET <= r_sync[SYNC_PRESET_HI:SYNC_PRESET_LO];
         SYNC_OUTPUT_DELAY <= r_sync[SYNC_OUT_DLY_HI:SYNC_OUT_DLY_LO];
         SYNC_INPUT_DELAY <= r_sync[SYNC_IN_DLY_HI:SYNC_IN_DLY_LO];
      end
   end

   // Ramp values gated to zero so a disabled generator sees nothing stale
   always_ff @(posedge CLOCK) begin
      if (RST || !RAMP_ENABLE) begin
         RAMP_UPPER_LIMIT <= 32'h0;
         RAMP_LOWER_LIMIT <= 32'h0;
         RAMP_DECREMENT_STEP <= 32'h0;
         RAMP_INCREMENT_STEP <= 32'h0;
         RAMP_DECREMENT_RATE <= 16'h0;
         RAMP_INCREMENT_RATE <= 16'h0;
      end else begin
         RAMP_UPPER_LIMIT <= r_lim[RAMP_HI_HI:RAMP_HI_LO];
         RAMP_LOWER_LIMIT <= r_lim[RAMP_LO_HI:RAMP_LO_LO];
         RAMP_DECREMENT_STEP <= r_step[RAMP_HI_HI:RAMP_HI_LO];
         RAMP_INCREMENT_STEP <= r_step[RAMP_LO_HI:RAMP_LO_LO];
         RAMP_DECREMENT_RATE <= r_rate[RATE_NEG_HI:RATE_NEG_LO];
         RAMP_INCREMENT_RATE <= r_rate[RATE_POS_HI:RATE_POS_LO];
      end
   end

   // ==========================================
   // Checks
   sequence seq_commit;
      wr_en && idx_q == 3'h3;
   endsequence
   sequence seq_sync_seen;
      ##2 SYNC_RECEIVER_ENABLE == $past(shift_q[SYNC_RX_EN_BIT], 2);
   endsequence

   AST_FREQ_FOLLOWS: assert property (@(posedge CLOCK) disable iff (RST)
      (wr_en && idx_q == 3'h0) |-> ##2 FREQUENCY_WORD == $past(shift_q[31:0], 2))
      else $error("frequency word not applied");
   AST_PHASE_FOLLOWS: assert property (@(posedge CLOCK) disable iff (RST)
      (wr_en && idx_q == 3'h1) |-> ##2 PHASE_OFFSET == $past(shift_q[15:0], 2))
      else $error("phase offset not applied");
   AST_SCALE_FOLLOWS: assert property (@(posedge CLOCK) disable iff (RST)
      (wr_en && idx_q == 3'h2) |-> ##2 AMPLITUDE_SCALE == $past(shift_q[15:2], 2))
      else $error("amplitude scale not applied");
   AST_KEYING_GATE: assert property (@(posedge CLOCK) disable iff (RST)
      !$past(keying_auto) |-> AMPLITUDE_RAMP_RATE == 16'h0 && AMPLITUDE_STEP == 2'h0)
      else $error("keying fields leak while keying off");
   AST_SYNC_RX: assert property (@(posedge CLOCK) disable iff (RST)
      seq_commit |-> seq_sync_seen)
      else $error("sync receiver enable not applied");
   AST_SYNC_GEN: assert property (@(posedge CLOCK) disable iff (RST)
      seq_commit |-> ##2 SYNC_GENERATOR_ENABLE == $past(shift_q[SYNC_GEN_EN_BIT], 2))
      else $error("sync generator enable not applied");
   AST_RAMP_GATE: assert property (@(posedge CLOCK) disable iff (RST)
      !$past(RAMP_ENABLE) |-> RAMP_UPPER_LIMIT == 32'h0 && RAMP_INCREMENT_RATE == 16'h0)
      else $error("ramp values leak while ramp disabled");
   AST_OPEN_ZERO: assert property (@(posedge CLOCK) disable iff (RST)
      r_sync[24] == 1'b0 && r_sync[17:16] == 2'h0 && r_phase[63:16] == 48'h0)
      else $error("open bit holds a value");
   AST_RESET_SYNC: assert property (@(posedge CLOCK)
      $past(RST) |-> r_sync == RESET_VALUE)
      else $error("sync register not cleared by reset");

   // Gated outputs follow their register one cycle late, never straight out of reset
   sequence seq_ramp_live;
      !$past(RST) && $past(RAMP_ENABLE);
   endsequence
   sequence seq_keying_live;
      !$past(RST) && $past(keying_auto);
   endsequence

   AST_KEYING_PASS: assert property (@(posedge CLOCK) disable iff (RST)
      seq_keying_live |-> AMPLITUDE_RAMP_RATE == $past(r_amp[ASF_RATE_HI:ASF_RATE_LO]) && AMPLITUDE_STEP == $past(r_amp[1:0]))
      else $error("keying fields not passed while keying on");
   AST_SYNC_DELAY: assert property (@(posedge CLOCK) disable iff (RST)
      seq_commit |-> ##2 SYNC_VALIDATION_DELAY == $past(shift_q[SYNC_VALID_HI:SYNC_VALID_LO], 2))
      else $error("sync validation delay not applied");
   AST_SYNC_EDGE: assert property (@(posedge CLOCK) disable iff (RST)
      seq_commit |-> ##2 SYNC_GENERATOR_FALLING == $past(shift_q[SYNC_GEN_POL_BIT], 2))
      else $error("sync generator edge not applied");
   AST_SYNC_PRESET: assert property (@(posedge CLOCK) disable iff (RST)
      seq_commit |-> ##2 SYNC_STATE_PRESET == $past(shift_q[SYNC_PRESET_HI:SYNC_PRESET_LO], 2))
      else $error("sync state preset not applied");
   AST_SYNC_OUT_DLY: assert property (@(posedge CLOCK) disable iff (RST)
      seq_commit |-> ##2 SYNC_OUTPUT_DELAY == $past(shift_q[SYNC_OUT_DLY_HI:SYNC_OUT_DLY_LO], 2))
      else $error("sync output delay not applied");
   AST_SYNC_IN_DLY: assert property (@(posedge CLOCK) disable iff (RST)
      seq_commit |-> ##2 SYNC_INPUT_DELAY == $past(shift_q[SYNC_IN_DLY_HI:SYNC_IN_DLY_LO], 2))
      else $error("sync input delay not applied");
   AST_RAMP_LIMITS: assert property (@(posedge CLOCK) disable iff (RST)
      seq_ramp_live |-> RAMP_UPPER_LIMIT == $past(r_lim[63:32]) && RAMP_LOWER_LIMIT == $past(r_lim[31:0]))
      else $error("ramp limits not passed while ramp on");
   AST_RAMP_STEPS: assert property (@(posedge CLOCK) disable iff (RST)
      seq_ramp_live |-> RAMP_DECREMENT_STEP == $past(r_step[63:32]) && RAMP_INCREMENT_STEP == $past(r_step[31:0]))
      else $error("ramp steps not passed while ramp on");
   AST_RAMP_RATES: assert property (@(posedge CLOCK) disable iff (RST)
      seq_ramp_live |-> RAMP_DECREMENT_RATE == $past(r_rate[31:16]) && RAMP_INCREMENT_RATE == $past(r_rate[15:0]))
      else $error("ramp rates not passed while ramp on");
   AST_OPEN_LOW: assert property (@(posedge CLOCK) disable iff (RST)
      r_sync[63:32] == 32'h0 && r_sync[10:8] == 3'h0 && r_sync[2:0] == 3'h0 && r_freq[63:32] == 32'h0)
      else $error("open sync or word bit holds a value");
endmodule : dds_tuning_sync_ramp_regs

// file: tb/host_port_model.sv
// Host model driving the byte-serial register access port
`timescale 1ns/10ps
module host_port_model
(
   input wire logic clock,
   output logic start,
   output logic wr,
   output logic [7:0] addr,
   output logic bvalid,
   output logic [7:0] bin,
   input wire logic [7:0] bout,
   input wire logic bout_valid,
   input wire logic done,
   input wire logic addr_err
);
   initial begin
      start = 1'b0;
      wr = 1'b0;
      addr = 8'h00;
      bvalid = 1'b0;
      bin = 8'h00;
   end
   // ==========================================
   // Bounded waits, 0 done, 1 read byte, 2 error
   task automatic await(input logic [1:0] sel, output bit ok);
      ok = 1'b0;
      for (int i = 0; i < 16; i++) begin
         #1;
         ok = (sel == 2'h0) ? done === 1'b1 : (sel == 2'h1) ? bout_valid === 1'b1 : addr_err === 1'b1;
         if (ok) break;
         @(posedge clock);
      end
   endtask : await
   // ==========================================
   // Access cycles
   task automatic begin_access(input logic [7:0] a, input logic w);
      @(posedge clock);
      start <= 1'b1;
      wr <= w;
      addr <= a;
      @(posedge clock);
      start <= 1'b0;
   endtask : begin_access
   task automatic write_reg(input logic [7:0] a, input int n, input logic [63:0] d, output bit ok);
      begin_access(a, 1'b1);
      for (int i = n - 1; i >= 0; i--) begin
         bvalid <= 1'b1;
         bin <= d[8*i +: 8];
         @(posedge clock);
      end
      // Released data line shows the inverse, not a stale byte
      bvalid <= 1'b0;
      bin <= ~d[7:0];
      await(2'h0, ok);
      if (ok) begin
         @(posedge clock);
         #1;
      end
   endtask : write_reg
   task automatic read_reg(input logic [7:0] a, input int n, output logic [63:0] d, output bit ok);
      d = 64'h0;
      ok = 1'b1;
      begin_access(a, 1'b0);
      for (int i = 0; i < n && ok; i++) begin
         @(posedge clock);
         bvalid <= 1'b1;
         @(posedge clock);
         bvalid <= 1'b0;
         await(2'h1, ok);
         d = {d[55:0], bout};
      end
   endtask : read_reg
   task automatic probe(input logic [7:0] a, output bit ok);
      begin_access(a, 1'b1);
      await(2'h2, ok);
   endtask : probe
endmodule : host_port_model

// file: tb/dds_tuning_sync_ramp_regs_test.sv
// Self-checking bench of the tuning, sync and ramp register bank
`timescale 1ns/10ps
module dds_tuning_sync_ramp_regs_test import dds_regs_pkg::*;;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [1:0] keying = 2'h0;
   logic ramp_en = 1'b0;
   logic start, wr, bvalid, done, addr_err, bout_valid, rx_en, gen_en, gen_fall;
   logic [7:0] addr, bin, bout;
   logic [31:0] freq, ramp_up, ramp_lo, ramp_dec, ramp_inc;
   logic [15:0] phase, amp_rate, rate_dec, rate_inc;
   logic [13:0] amp_scale;
   logic [1:0] amp_step;
   logic [3:0] val_dly;
   logic [5:0] preset;
   logic [4:0] out_dly, in_dly;
   logic [63:0] rdata;
   bit ok;
   int err_total = 0;
   int n_tests = 0;
   logic [63:0] wdata [7] = '{64'h89ab_cdef, 64'ha5c3, 64'h1234_abcd, 64'hffff_ffff, 64'h0123_4567_89ab_cdef,
      64'hfedc_ba98_7654_3210, 64'h5a5a_c3c3};
   logic [63:0] masks [7] = '{MASK_WORD32, MASK_PHASE_OFFSET, MASK_WORD32, MASK_MULTICHIP_SYNC, MASK_WORD64,
      MASK_WORD64, MASK_WORD32};
   logic [3:0] nbytes [7] = '{BYTES_FREQUENCY_WORD, BYTES_PHASE_OFFSET, BYTES_AMPLITUDE_SCALE, BYTES_MULTICHIP_SYNC,
      BYTES_RAMP_LIMITS, BYTES_RAMP_STEPS, BYTES_RAMP_RATES};
   always #10 clock = ~clock;
   dds_tuning_sync_ramp_regs uut (.CLOCK(clock), .RST(rst), .ACCESS_START(start), .ACCESS_WRITE(wr),
      .ACCESS_ADDR(addr), .BYTE_VALID(bvalid), .BYTE_IN(bin), .KEYING_CONTROL(keying), .RAMP_ENABLE(ramp_en),
      .BYTE_OUT(bout), .BYTE_OUT_VALID(bout_valid), .ACCESS_DONE(done), .ADDR_ERROR(addr_err),
      .FREQUENCY_WORD(freq), .PHASE_OFFSET(phase), .AMPLITUDE_SCALE(amp_scale), .AMPLITUDE_RAMP_RATE(amp_rate),
      .AMPLITUDE_STEP(amp_step), .SYNC_VALIDATION_DELAY(val_dly), .SYNC_RECEIVER_ENABLE(rx_en),
      .SYNC_GENERATOR_ENABLE(gen_en), .SYNC_GENERATOR_FALLING(gen_fall), .SYNC_STATE_PRESET(preset),
      .SYNC_OUTPUT_DELAY(out_dly), .SYNC_INPUT_DELAY(in_dly), .RAMP_UPPER_LIMIT(ramp_up),
      .RAMP_LOWER_LIMIT(ramp_lo), .RAMP_DECREMENT_STEP(ramp_dec), .RAMP_INCREMENT_STEP(ramp_inc),
      .RAMP_DECREMENT_RATE(rate_dec), .RAMP_INCREMENT_RATE(rate_inc));
   host_port_model host (.clock(clock), .start(start), .wr(wr), .addr(addr), .bvalid(bvalid), .bin(bin),
      .bout(bout), .bout_valid(bout_valid), .done(done), .addr_err(addr_err));
   // ==========================================
   // Reporting
   task automatic check_val(input string what, input logic [63:0] exp, input logic [63:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h got %h", what, exp, got);
      end
   endtask : check_val
   task automatic tally_and_finish();
      if (err_total == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish
   // Hung handshake ends the run at once
   task automatic guard(input bit good);
      if (!good) begin
         err_total++;
         $display("ERROR handshake expected 1 got 0");
         tally_and_finish();
      end
   endtask : guard
   // ==========================================
   // Access and field checks
   task automatic wr_reg(input int i, input logic [63:0] d);
      host.write_reg(8'(FIRST_ADDR + i), int'(nbytes[i]), d, ok);
      guard(ok);
   endtask : wr_reg
   task automatic rd_chk(input int i, input logic [63:0] exp);
      host.read_reg(8'(FIRST_ADDR + i), int'(nbytes[i]), rdata, ok);
      guard(ok);
      check_val("readback", exp, rdata);
   endtask : rd_chk
   task automatic check_sync(input logic [31:0] v);
      check_val("sync_delay", 64'(v[SYNC_VALID_HI:SYNC_VALID_LO]), 64'(val_dly));
      check_val("sync_rx", 64'(v[SYNC_RX_EN_BIT]), 64'(rx_en));
      check_val("sync_gen", 64'(v[SYNC_GEN_EN_BIT]), 64'(gen_en));
      check_val("sync_edge", 64'(v[SYNC_GEN_POL_BIT]), 64'(gen_fall));
      check_val("sync_preset", 64'(v[SYNC_PRESET_HI:SYNC_PRESET_LO]), 64'(preset));
      check_val("sync_out", 64'(v[SYNC_OUT_DLY_HI:SYNC_OUT_DLY_LO]), 64'(out_dly));
      check_val("sync_in", 64'(v[SYNC_IN_DLY_HI:SYNC_IN_DLY_LO]), 64'(in_dly));
   endtask : check_sync
   task automatic check_ramp(input logic on);
      check_val("ramp_limits", on ? wdata[4] : 64'h0, {ramp_up, ramp_lo});
      check_val("ramp_steps", on ? wdata[5] : 64'h0, {ramp_dec, ramp_inc});
      check_val("ramp_rates", on ? wdata[6] : 64'h0, 64'({rate_dec, rate_inc}));
   endtask : check_ramp
   task automatic settle();
      repeat (2) @(posedge clock);
      #1;
   endtask : settle
   // ==========================================
   // Main sequence
   initial begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      #1;
      check_sync(32'h0);
      for (int i = 0; i < 7; i++) rd_chk(i, RESET_VALUE);
      for (int i = 0; i < 7; i++) wr_reg(i, wdata[i]);
      check_val("freq", wdata[0], 64'(freq));
      check_val("phase", wdata[1], 64'(phase));
      check_val("amp_scale", 64'(wdata[2][ASF_SCALE_HI:ASF_SCALE_LO]), 64'(amp_scale));
      check_sync(wdata[3][31:0]);
      check_ramp(1'b0);
      for (int k = 0; k < 4; k++) begin
         @(posedge clock);
         keying <= 2'(k);
         settle();
         check_val("amp_ramp", (2'(k) == KEYING_AUTO) ? 64'({wdata[2][ASF_RATE_HI:ASF_RATE_LO],
            wdata[2][ASF_STEP_HI:ASF_STEP_LO]}) : 64'h0, 64'({amp_rate, amp_step}));
      end
      @(posedge clock);
      ramp_en <= 1'b1;
      settle();
      check_ramp(1'b1);
      for (int i = 0; i < 7; i++) rd_chk(i, wdata[i] & masks[i]);
      wr_reg(3, 64'h9a5c_5a28);
      check_sync(32'h9a5c_5a28);
      rd_chk(3, 64'h9a5c_5828);
      foreach (masks[j]) begin
         host.probe(8'(j == 0 ? 6 : 14 + j), ok);
         guard(ok);
      end
      check_val("freq_kept", wdata[0], 64'(freq));
      @(posedge clock);
      ramp_en <= 1'b0;
      settle();
      check_ramp(1'b0);
      // Mid-run reset must clear the sync enables again
      @(posedge clock);
      rst <= 1'b1;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      settle();
      check_val("freq_reset", 64'h0, 64'(freq));
      check_sync(32'h0);
      rd_chk(3, RESET_VALUE);
      wr_reg(1, 64'h5a5a);
      check_val("phase_after_reset", 64'h5a5a, 64'(phase));
      tally_and_finish();
   end
endmodule : dds_tuning_sync_ramp_regs_test
